// ==== hw/ssp_pkg.sv ====
package ssp_pkg;
    // Printed offsets are register indices; byte address is four times
    localparam logic [7:0] IDX_CTRL1  = 8'h00;
    localparam logic [7:0] IDX_CTRL2  = 8'h01;
    localparam logic [7:0] IDX_BAUD   = 8'h02;
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_DATA   = 8'h05;
    localparam logic [7:0] ADDR_CTRL1  = 8'(IDX_CTRL1 * 4);
    localparam logic [7:0] ADDR_CTRL2  = 8'(IDX_CTRL2 * 4);
    localparam logic [7:0] ADDR_BAUD   = 8'(IDX_BAUD * 4);
    localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
    localparam logic [7:0] ADDR_DATA   = 8'(IDX_DATA * 4);

    // control_register_one fields
    localparam int B_IRQ_EN    = 7;
    localparam int B_PORT_EN   = 6;
    localparam int B_TXIRQ_EN  = 5;
    localparam int B_CTRL_SEL  = 4;
    localparam int B_CLK_INV   = 3;
    localparam int B_CLK_PHASE = 2;
    // control_register_two fields
    localparam int B_FAULT_EN  = 4;
    // baud register fields
    localparam int B_PRESC_LO  = 4;
    localparam int B_SHIFT_LO  = 0;
    // port_status_flags fields
    localparam int B_DONE      = 7;
    localparam int B_TXE       = 5;
    localparam int B_MODE_FAULT_FLAG      = 4;

    localparam logic [7:0] RST_CTRL1 = 8'h04;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_BAUD  = 8'h00;

    localparam logic [4:0] EDGES_PER_XFER = 5'h10;
    localparam int         HALF_W         = 11;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_RUN  = 2'b01
    } ssp_state_t;

    // Half of the divisor: (p+1)*2^s bus cycles per clock edge
    function automatic logic [HALF_W-1:0] half_period(input logic [2:0] p, input logic [2:0] s);
        logic [HALF_W-1:0] base;
        base = HALF_W'(p) + HALF_W'(1);
        return base << s;
    endfunction
endpackage

// ==== hw/ssp_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_baud (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       restart,
    input  wire logic [2:0] presc_sel,
    input  wire logic [2:0] shift_sel,
    output logic            half_tick
);
    logic [ssp_pkg::HALF_W-1:0] cnt_ff;
    logic [ssp_pkg::HALF_W-1:0] half_len;

    assign half_len  = ssp_pkg::half_period(presc_sel, shift_sel);
    // One pulse per half clock period, first one half a period after restart
    assign half_tick = !restart && (cnt_ff == half_len - ssp_pkg::HALF_W'(1));

    always_ff @(posedge mclk) begin
        if (rst || restart || half_tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + ssp_pkg::HALF_W'(1);
        end
    end
endmodule // ssp_baud
`default_nettype wire

// ==== hw/ssp_top.sv ====
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ssp_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sel_n_in,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe_n,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe_n,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe_n,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]          ctrl1_ff;
    logic [7:0]          ctrl2_ff;
    logic [7:0]          baud_ff;
    logic [7:0]          tx_buf_ff;
    logic                tx_full_ff;
    logic [7:0]          rx_buf_ff;
    logic [7:0]          shift_ff;
    logic                out_bit_ff;
    logic                sclk_ff;
    logic [4:0]          edge_cnt_ff;
    logic                done_flag_ff;
    logic                mode_fault_flag_flag_ff;
    logic                arm_done_ff;
    logic                arm_tx_ff;
    logic                arm_mode_fault_flag_ff;
    logic                dph_wr_ff;
    logic [7:0]          dph_addr_ff;
    logic [31:0]         hrdata_ff;
    logic                sel_s1_ff;
    logic                sel_s2_ff;
    logic                sck_s1_ff;
    logic                sck_s2_ff;
    logic                sck_s3_ff;
    logic                mosi_s1_ff;
    logic                mosi_s2_ff;
    logic                miso_s1_ff;
    logic                miso_s2_ff;
    ssp_pkg::ssp_state_t state_ff;
    ssp_pkg::ssp_state_t nxt_state;

    logic       port_en;
    logic       is_ctrl;
    logic       clock_phase_sel;
    logic [7:0] status;
    logic       addr_ok;
    logic       rd_ev;
    logic       rd_status;
    logic       rd_data;
    logic       wr_ctrl1;
    logic       wr_ctrl2;
    logic       wr_baud;
    logic       wr_data;
    logic       wr_status;
    logic       tx_accept;
    logic       baud_chg;
    logic       mode_fault_flag_ev;
    logic       abort;
    logic       start;
    logic       half_tick;
    logic       edge_ev;
    logic [4:0] edge_num;
    logic       sample_edge;
    logic       done_ev;
    logic       din;
    logic [7:0] rx_next;

    ////////////////////////////////////////////////////////////////////////////////
    assign port_en = ctrl1_ff[ssp_pkg::B_PORT_EN];
    assign is_ctrl = ctrl1_ff[ssp_pkg::B_CTRL_SEL];
    assign clock_phase_sel    = ctrl1_ff[ssp_pkg::B_CLK_PHASE];
    assign status  = {done_flag_ff, 1'b0, !tx_full_ff, mode_fault_flag_flag_ff, 4'h0};

    // Only address-phase reads have side effects; the slave never stalls
    assign addr_ok   = hsel && htrans[1] && hready;
    assign rd_ev     = addr_ok && !hwrite;
    assign rd_status = rd_ev && (haddr == ssp_pkg::ADDR_STATUS);
    assign rd_data   = rd_ev && (haddr == ssp_pkg::ADDR_DATA);
    assign wr_ctrl1  = dph_wr_ff && (dph_addr_ff == ssp_pkg::ADDR_CTRL1);
    assign wr_ctrl2  = dph_wr_ff && (dph_addr_ff == ssp_pkg::ADDR_CTRL2);
    assign wr_baud   = dph_wr_ff && (dph_addr_ff == ssp_pkg::ADDR_BAUD);
    assign wr_data   = dph_wr_ff && (dph_addr_ff == ssp_pkg::ADDR_DATA);
    assign wr_status = dph_wr_ff && (dph_addr_ff == ssp_pkg::ADDR_STATUS);
    assign tx_accept = wr_data && arm_tx_ff;

    assign baud_chg = wr_baud && ((hwdata[6:4] != baud_ff[6:4]) || (hwdata[2:0] != baud_ff[2:0]));
    assign mode_fault_flag_ev  = port_en && is_ctrl && ctrl2_ff[ssp_pkg::B_FAULT_EN] && !sel_s2_ff;
    // Target aborts when deselected; controller on fault or baud change
    assign abort    = !port_en || mode_fault_flag_ev || (is_ctrl && baud_chg) || (!is_ctrl && sel_s2_ff);
    assign start    = (state_ff == ssp_pkg::SSP_IDLE) && port_en && !abort
                      && (is_ctrl ? tx_full_ff : !sel_s2_ff);

    assign edge_ev     = (state_ff == ssp_pkg::SSP_RUN) && !abort
                         && (is_ctrl ? half_tick : (sck_s2_ff ^ sck_s3_ff));
    assign edge_num    = edge_cnt_ff + 5'h01;
    assign sample_edge = edge_num[0] ^ clock_phase_sel;
    assign done_ev     = edge_ev && (edge_num == ssp_pkg::EDGES_PER_XFER);
    // Synchroniser delay: controller reception needs half periods of three cycles or more
    assign din         = is_ctrl ? miso_s2_ff : mosi_s2_ff;
    // With phase 1 the last edge samples, so the final bit is not yet shifted in
    assign rx_next     = sample_edge ? {shift_ff[6:0], din} : shift_ff;

    ////////////////////////////////////////////////////////////////////////////////
    ssp_baud u_baud (
        .mclk      (mclk),
        .rst       (rst),
        .restart   (state_ff != ssp_pkg::SSP_RUN),
        .presc_sel (baud_ff[6:4]),
        .shift_sel (baud_ff[2:0]),
        .half_tick (half_tick)
    );

    // Pins are two-stage synchronised; third sclk stage only for edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_s1_ff  <= 1'b1;
            sel_s2_ff  <= 1'b1;
            sck_s1_ff  <= 1'b0;
            sck_s2_ff  <= 1'b0;
            sck_s3_ff  <= 1'b0;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
        end else begin
            sel_s1_ff  <= sel_n_in;
            sel_s2_ff  <= sel_s1_ff;
            sck_s1_ff  <= sclk_in;
            sck_s2_ff  <= sck_s1_ff;
            sck_s3_ff  <= sck_s2_ff;
            mosi_s1_ff <= mosi_in;
            mosi_s2_ff <= mosi_s1_ff;
            miso_s1_ff <= miso_in;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            dph_wr_ff   <= 1'b0;
            dph_addr_ff <= 8'h00;
            hrdata_ff   <= 32'h00000000;
        end else begin
            dph_wr_ff   <= addr_ok && hwrite;
            dph_addr_ff <= haddr;
            if (rd_ev) begin
                case (haddr)
                    ssp_pkg::ADDR_CTRL1:  hrdata_ff <= {24'h000000, ctrl1_ff};
                    ssp_pkg::ADDR_CTRL2:  hrdata_ff <= {24'h000000, ctrl2_ff};
                    ssp_pkg::ADDR_BAUD:   hrdata_ff <= {24'h000000, baud_ff};
                    ssp_pkg::ADDR_STATUS: hrdata_ff <= {24'h000000, status};
                    ssp_pkg::ADDR_DATA:   hrdata_ff <= {24'h000000, rx_buf_ff};
                    default:              hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    // Fault clears controller role in the same register software writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl1_ff <= ssp_pkg::RST_CTRL1;
            ctrl2_ff <= ssp_pkg::RST_CTRL2;
            baud_ff  <= ssp_pkg::RST_BAUD;
        end else begin
            if (wr_ctrl1) begin
                ctrl1_ff <= {hwdata[7:2], 2'b00};
            end
            if (mode_fault_flag_ev) begin
                ctrl1_ff[ssp_pkg::B_CTRL_SEL] <= 1'b0;
            end
            if (wr_ctrl2) begin
                ctrl2_ff <= {3'b000, hwdata[ssp_pkg::B_FAULT_EN], 4'h0};
            end
            if (wr_baud) begin
                baud_ff <= {1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arms remember what the last status read saw until the matching access
    always_ff @(posedge mclk) begin
        if (rst) begin
            arm_done_ff <= 1'b0;
            arm_tx_ff   <= 1'b0;
            arm_mode_fault_flag_ff <= 1'b0;
        end else begin
            if (rd_status) begin
                arm_done_ff <= done_flag_ff;
                arm_tx_ff   <= !tx_full_ff;
                arm_mode_fault_flag_ff <= mode_fault_flag_flag_ff;
            end else begin
                if (rd_data) begin
                    arm_done_ff <= 1'b0;
                end
                if (wr_data) begin
                    arm_tx_ff <= 1'b0;
                end
                if (wr_ctrl1) begin
                    arm_mode_fault_flag_ff <= 1'b0;
                end
            end
        end
    end

    // Set wins over clear for every flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            done_flag_ff <= 1'b0;
            mode_fault_flag_flag_ff <= 1'b0;
        end else begin
            if (done_ev) begin
                done_flag_ff <= 1'b1;
            end else if (rd_data && arm_done_ff && !rd_status) begin
                done_flag_ff <= 1'b0;
            end
            if (mode_fault_flag_ev) begin
                mode_fault_flag_flag_ff <= 1'b1;
            end else if (wr_ctrl1 && arm_mode_fault_flag_ff && !rd_status) begin
                mode_fault_flag_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_buf_ff  <= 8'h00;
            tx_full_ff <= 1'b0;
        end else begin
            if (tx_accept) begin
                tx_buf_ff  <= hwdata[7:0];
                tx_full_ff <= 1'b1;
            end else if (start && tx_full_ff) begin
                tx_full_ff <= 1'b0;
            end
        end
    end

    // Later bytes are dropped while an earlier one is unserviced
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_buf_ff <= 8'h00;
        end else if (done_ev && !done_flag_ff) begin
            rx_buf_ff <= rx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ssp_pkg::SSP_IDLE: begin
                if (start) begin
                    nxt_state = ssp_pkg::SSP_RUN;
                end
            end
            ssp_pkg::SSP_RUN: begin
                if (abort || done_ev) begin
                    nxt_state = ssp_pkg::SSP_IDLE;
                end
            end
            default: nxt_state = ssp_pkg::SSP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ssp_pkg::SSP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Local half of the 16-bit ring: sample shifts in, launch drives out
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_ff    <= 8'h00;
            out_bit_ff  <= 1'b0;
            edge_cnt_ff <= 5'h00;
        end else if (start) begin
            // An idle target with nothing queued resends its last shifter
            shift_ff    <= tx_full_ff ? tx_buf_ff : shift_ff;
            out_bit_ff  <= tx_full_ff ? tx_buf_ff[7] : shift_ff[7];
            edge_cnt_ff <= 5'h00;
        end else if (edge_ev) begin
            edge_cnt_ff <= edge_num;
            if (sample_edge) begin
                shift_ff <= {shift_ff[6:0], din};
            end else begin
                out_bit_ff <= shift_ff[7];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_ff <= 1'b0;
        end else if (state_ff != ssp_pkg::SSP_RUN || !is_ctrl) begin
            sclk_ff <= ctrl1_ff[ssp_pkg::B_CLK_INV];
        end else if (edge_ev) begin
            sclk_ff <= !sclk_ff;
        end
    end

    // Output enables are active low; a target drives only while selected and fault-free
    assign sclk_out  = sclk_ff;
    assign mosi_out  = out_bit_ff;
    assign miso_out  = out_bit_ff;
    assign sclk_oe_n = !(port_en && is_ctrl);
    assign mosi_oe_n = !(port_en && is_ctrl);
    assign miso_oe_n = !(port_en && !is_ctrl && !sel_s2_ff && !mode_fault_flag_flag_ff);

    assign irq = (ctrl1_ff[ssp_pkg::B_IRQ_EN] && (done_flag_ff || mode_fault_flag_flag_ff))
                 || (ctrl1_ff[ssp_pkg::B_TXIRQ_EN] && !tx_full_ff);

    ////////////////////////////////////////////////////////////////////////////////
    logic [ssp_pkg::HALF_W-1:0] gap_ff;

    always_ff @(posedge mclk) begin
        if (rst || start || edge_ev) begin
            gap_ff <= '0;
        end else begin
            gap_ff <= gap_ff + ssp_pkg::HALF_W'(1);
        end
    end

    property p_edge_rate;
        @(posedge mclk) disable iff (rst)
        (edge_ev && is_ctrl && !$past(wr_baud))
            |-> (gap_ff + ssp_pkg::HALF_W'(1)) == ssp_pkg::half_period(baud_ff[6:4], baud_ff[2:0]);
    endproperty
    a_edge_rate: assert property (p_edge_rate) else $error("controller edge spacing wrong");

    property p_status_ro;
        @(posedge mclk) disable iff (rst)
        (wr_status && !done_ev && !mode_fault_flag_ev && !tx_accept && !start && !rd_data)
            |=> status == $past(status);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status changed by a write");

    property p_done_set;
        @(posedge mclk) disable iff (rst)
        done_ev |=> done_flag_ff;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_done_clear;
        @(posedge mclk) disable iff (rst)
        $fell(done_flag_ff) |-> $past(rd_data && arm_done_ff);
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag cleared wrongly");

    property p_tx_accept;
        @(posedge mclk) disable iff (rst)
        $rose(tx_full_ff) |-> $past(wr_data && arm_tx_ff);
    endproperty
    a_tx_accept: assert property (p_tx_accept) else $error("data write taken unarmed");

    property p_fault;
        @(posedge mclk) disable iff (rst)
        mode_fault_flag_ev |=> mode_fault_flag_flag_ff && !is_ctrl && state_ff == ssp_pkg::SSP_IDLE && sclk_oe_n
            && miso_oe_n;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled");

    property p_overrun;
        @(posedge mclk) disable iff (rst)
        (done_ev && done_flag_ff) |=> $stable(rx_buf_ff) ##1 $stable(rx_buf_ff) or !done_flag_ff;
    endproperty
    a_overrun: assert property (p_overrun) else $error("unserviced byte overwritten");

    property p_back_to_back;
        @(posedge mclk) disable iff (rst)
        (done_ev && is_ctrl && tx_full_ff && port_en && !abort) |=> ##1 state_ff == ssp_pkg::SSP_RUN
            || abort || !tx_full_ff;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("queued byte not started");

    property p_pins_off;
        @(posedge mclk) disable iff (rst)
        !port_en |-> sclk_oe_n && mosi_oe_n && miso_oe_n;
    endproperty
    a_pins_off: assert property (p_pins_off) else $error("pin driven while disabled");

    property p_baud_abort;
        @(posedge mclk) disable iff (rst)
        (baud_chg && is_ctrl && state_ff == ssp_pkg::SSP_RUN) |=> state_ff == ssp_pkg::SSP_IDLE;
    endproperty
    a_baud_abort: assert property (p_baud_abort) else $error("baud change did not abort");
endmodule // ssp_top
`default_nettype wire

// ==== verif/ssp_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_remote (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       clock_phase_sel,
    input  wire logic       act,
    input  wire logic       ld,
    input  wire logic [7:0] ld_val,
    output logic            miso,
    output logic [7:0]      shreg
);
    logic       lat;
    logic [4:0] n;
    // Unselected line shows the inverse, never a held bit
    assign miso = act ? shreg[7] : ~shreg[7];
    always @(posedge ld) begin
        shreg = ld_val;
        n = 5'h00;
    end
    // Only follows the port's clock; as target it never sets the rate
    always @(sclk) begin
        if (act) begin
            n = n + 5'h01;
            if (n[0] ^ clock_phase_sel) lat = mosi;
            else if (n > 5'h01) shreg = {shreg[6:0], lat};
            if (clock_phase_sel && n == 5'h10) shreg = {shreg[6:0], lat};
            // No select from the port, so frames are counted back to back
            if (n == 5'h10) n = 5'h00;
        end
    end
endmodule // ssp_remote
`default_nettype wire

// ==== verif/tb_spi_status_data_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_spi_status_data_baud;
    logic        mclk, rst, hsel, hwrite, sel_n, ld, act, clock_phase_sel, meas, seen, rd_dp;
    logic        hreadyout, hresp, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso;
    logic        miso_o, miso_oe_n, irq, sclk_q;
    logic [1:0]  htrans;
    logic [7:0]  haddr, ld_val, tx, shreg;
    logic [10:0] half, cnt;
    logic [31:0] hwdata, hrdata, rd_val;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int          bad_count, check_count, k;
    logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
    logic [7:0]  rv[5] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00};
    // Half periods of three or more: input synchronisers delay reception
    logic [7:0]  cf[8] = '{8'h50, 8'h47, 8'h5C, 8'h12, 8'h58, 8'h21, 8'h50, 8'h20};
    ssp_top ssp_top_inst (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sel_n_in(sel_n), .sclk_in(sclk_oe_n ? ~sclk_o : sclk_o), .sclk_out(sclk_o),
        .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_oe_n ? ~mosi_o : mosi_o), .mosi_out(mosi_o),
        .mosi_oe_n(mosi_oe_n), .miso_in(miso_oe_n ? miso : miso_o), .miso_out(miso_o),
        .miso_oe_n(miso_oe_n), .irq(irq));
    ssp_remote ssp_remote_inst (.sclk(sclk_oe_n ? ~sclk_o : sclk_o),
        .mosi(mosi_oe_n ? ~mosi_o : mosi_o), .clock_phase_sel(clock_phase_sel), .act(act), .ld(ld),
        .ld_val(ld_val), .miso(miso), .shreg(shreg));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask
    // Upper bytes are always checked as zero
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({24'hFFFFFF, m, 24'h0, e});
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic poll(input int b);
        k = 0;
        do begin
            rd(ssp_pkg::ADDR_STATUS, 8'h00, 8'h00);
            k++;
        end while (rd_val[b] !== 1'b1 && k < 6000);
        `CHK("status poll", 1'b1, rd_val[b])
    endtask
    task automatic load_remote();
        ld_val = 8'($urandom);
        ld <= 1'b1;
        @(posedge mclk);
        ld <= 1'b0;
        act <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (rd_dp === 1'b1) begin
            note = exp_q.pop_front();
            `CHK("hrdata", note[31:0], hrdata & note[63:32])
        end
        rd_dp = hsel && htrans[1] && !hwrite && hreadyout;
        sclk_q <= sclk_o;
        cnt <= (sclk_o != sclk_q) ? 11'h1 : cnt + 11'h1;
        if (sclk_o != sclk_q && meas) begin
            if (seen) `CHK("half period", half, cnt)
            seen <= 1'b1;
        end
        if (!meas) seen <= 1'b0;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        close_out();
    end
    initial begin
        {hsel, hwrite, ld, act, clock_phase_sel, meas, seen, rd_dp, sclk_q} = '0;
        {haddr, htrans, hwdata, cnt, half, ld_val} = '0;
        sel_n = 1'b1;
        rst = 1'b1;
        void'($urandom(49981));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        // Unarmed write must leave the buffer empty
        bus(ssp_pkg::ADDR_DATA, 1'b1, 32'h5A);
        rd(ssp_pkg::ADDR_STATUS, 8'hFF, 8'h20);
        bus(ssp_pkg::ADDR_STATUS, 1'b1, 32'hFF);
        `CHK("hresp", 1'b0, hresp)
        `CHK("oe_n idle", 3'b111, {sclk_oe_n, mosi_oe_n, miso_oe_n})
        foreach (ra[i]) rd(ra[i], 8'hFF, rv[i]);
        for (int i = 0; i < 8; i += 2) begin
            bus(ssp_pkg::ADDR_CTRL1, 1'b1, {24'h0, cf[i]});
            bus(ssp_pkg::ADDR_BAUD, 1'b1, {24'h0, cf[i+1]});
            half = (11'(cf[i+1][6:4]) + 11'h1) << cf[i+1][2:0];
            clock_phase_sel = cf[i][2];
            load_remote();
            meas <= 1'b1;
            tx = 8'($urandom);
            rd(ssp_pkg::ADDR_STATUS, 8'hB0, 8'h20);
            bus(ssp_pkg::ADDR_DATA, 1'b1, {24'h0, tx});
            `CHK("sclk_oe_n", 1'b0, sclk_oe_n)
            poll(7);
            meas <= 1'b0;
            act <= 1'b0;
            rd(ssp_pkg::ADDR_DATA, 8'hFF, ld_val);
            rd(ssp_pkg::ADDR_STATUS, 8'h80, 8'h00);
            `CHK("remote rx", tx, shreg)
            `CHK("sclk idle", cf[i][3], sclk_o)
        end
        // Two transfers back to back, first received byte never serviced
        load_remote();
        rd(ssp_pkg::ADDR_STATUS, 8'h20, 8'h20);
        bus(ssp_pkg::ADDR_DATA, 1'b1, {24'h0, tx});
        poll(5);
        tx = 8'($urandom);
        bus(ssp_pkg::ADDR_DATA, 1'b1, {24'h0, tx});
        for (k = 0; k < 400 && shreg !== tx; k++) @(posedge mclk);
        `CHK("queued byte sent", tx, shreg)
        repeat (4) @(posedge mclk);
        rd(ssp_pkg::ADDR_DATA, 8'hFF, ld_val);
        act <= 1'b0;
        // Select pulled low under a live controller
        bus(ssp_pkg::ADDR_CTRL2, 1'b1, 32'h10);
        sel_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(ssp_pkg::ADDR_STATUS, 8'h10, 8'h10);
        rd(ssp_pkg::ADDR_CTRL1, 8'h10, 8'h00);
        `CHK("oe_n", 3'b111, {sclk_oe_n, mosi_oe_n, miso_oe_n})
        sel_n <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(ssp_pkg::ADDR_CTRL1, 1'b1, 32'hD0);
        rd(ssp_pkg::ADDR_STATUS, 8'h10, 8'h00);
        `CHK("irq", 1'b1, irq)
        rd(ssp_pkg::ADDR_DATA, 8'h00, 8'h00);
        `CHK("irq", 1'b0, irq)
        // Baud change one edge into a slow transfer must abort it
        bus(ssp_pkg::ADDR_BAUD, 1'b1, 32'h47);
        load_remote();
        rd(ssp_pkg::ADDR_STATUS, 8'hB0, 8'h20);
        bus(ssp_pkg::ADDR_DATA, 1'b1, {24'h0, tx});
        repeat (700) @(posedge mclk);
        bus(ssp_pkg::ADDR_BAUD, 1'b1, 32'h20);
        repeat (200) @(posedge mclk);
        rd(ssp_pkg::ADDR_STATUS, 8'hB0, 8'h20);
        // Let the last read's data phase reach the checker
        @(posedge mclk);
        close_out();
    end
endmodule // tb_spi_status_data_baud
`default_nettype wire
